// File: rtl/dpc_top.sv
// digital pin configuration: direction, data, resource routing and eeprom pin takeover
//
// The AHB-Lite register port was decided locally.
`default_nettype none
module dpc_top (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pads
    input wire logic [dpc_pkg::NUM_PIN-1:0] pin_in,
    output logic [dpc_pkg::NUM_PIN-1:0] pin_out,
    output logic [dpc_pkg::NUM_PIN-1:0] pin_oe,
    input wire logic pushbutton_input,
    // internal resources
    output logic timer_zero_input,
    output logic timer_one_input,
    output logic external_interrupt_a,
    output logic external_interrupt_b,
    // eeprom engine side
    input wire logic eeprom_serial_clock,
    input wire logic eeprom_sda_out,
    input wire logic eeprom_sda_oe,
    output logic eeprom_sda_in,
    output logic eeprom_enable,
    output logic eeprom_three_wire
);
    import dpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    dpc_bus_st_t st_q;                       // bus data phase state
    logic [15:0] addr_q;                     // word index of the pending transfer
    logic addr_ok_q;                         // upper and low address bits clean
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdata;                      // read mux
    logic accept;                            // address phase taken
    logic wr_en;                             // write data phase
    logic [7:0] wbyte;                       // written byte
    logic [NUM_PIN-1:0] sync1_q;             // first synchroniser stage
    logic [NUM_PIN-1:0] lvl_q;               // synchronised pin levels
    logic pb_sync1_q;
    logic pb_q;                              // synchronised pushbutton
    logic [14:0] dir_q;                      // low pin directions, 1 = output
    logic [14:0] val_q;                      // low pin output latches
    logic [1:0] high_q [NUM_HIGH];           // high pin control bytes
    logic [2:0] sel_q [NUM_SRC];             // resource selectors
    logic [1:0] eex_q;                       // eeprom pin function
    logic [NUM_SRC-1:0] src;                 // selector inputs
    logic [3:0] contrib [NUM_SRC];           // per input resource hits
    logic [NUM_SRC-1:0] sel_live;            // selector holds a nonzero code
    logic [3:0] res_or;                      // merged resources
    logic [NUM_PIN-1:0] out_d;
    logic [NUM_PIN-1:0] oe_d;
    logic [NUM_PIN-1:0] pin_out_q;
    logic [NUM_PIN-1:0] pin_oe_q;
    logic [3:0] res_q;
    logic sda_in_q;
    logic ee_en_q;
    logic ee_three_q;

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave
    assign accept = hsel && hready && htrans[1] && hreadyout_q;
    assign wr_en = ce && (st_q == ST_WR) && addr_ok_q;
    assign wbyte = hwdata[7:0];

    // phase tracking: writes take no wait, reads one wait state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            addr_q <= 16'h0000;
            addr_ok_q <= 1'b0;
            hreadyout_q <= 1'b1;
        end else if (ce) begin
            unique case (st_q)
                ST_IDLE, ST_WR: begin
                    if (accept) begin
                        st_q <= hwrite ? ST_WR : ST_RD;
                        addr_q <= haddr[17:2];
                        addr_ok_q <= (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
                        hreadyout_q <= hwrite;
                    end else begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_RD: begin
                    // read data lands now, any earlier write already stored
                    st_q <= ST_IDLE;
                    hreadyout_q <= 1'b1;
                end
                default: begin
                    st_q <= ST_IDLE;
                    hreadyout_q <= 1'b1;
                end
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ce && st_q == ST_RD) begin
            hrdata_q <= addr_ok_q ? rdata : 32'h0000_0000;
        end
    end

    // read mux: port bytes hold direction in upper nibble, live level in lower
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (addr_q)
            IDX_PORT0: rdata[7:0] = {dir_q[3:0], lvl_q[3:0]};
            IDX_PORT1: rdata[7:0] = {dir_q[7:4], lvl_q[7:4]};
            IDX_PORT2: rdata[7:0] = {dir_q[11:8], lvl_q[11:8]};
            IDX_PORT3: rdata[7:0] = {1'b0, dir_q[14:12], 1'b0, lvl_q[14:12]};
            IDX_SEL_PB: rdata[7:0] = {5'h00, sel_q[0]};
            IDX_SEL_10: rdata[7:0] = {1'b0, sel_q[10], 1'b0, sel_q[9]};
            IDX_SEL_8: rdata[7:0] = {1'b0, sel_q[8], 1'b0, sel_q[7]};
            IDX_SEL_6: rdata[7:0] = {1'b0, sel_q[6], 1'b0, sel_q[5]};
            IDX_SEL_4: rdata[7:0] = {1'b0, sel_q[4], 1'b0, sel_q[3]};
            IDX_SEL_2: rdata[7:0] = {1'b0, sel_q[2], 1'b0, sel_q[1]};
            IDX_EEX: rdata[7:0] = {eex_q, 6'h00};
            default: begin
                // high pin control bytes, value bit reads the pin level
                for (int k = 0; k < NUM_HIGH; k++) begin
                    if (addr_q == IDX_HIGH0 + 16'(k)) begin
                        rdata[7:0] = {6'h00, high_q[k][HIGH_DIR], lvl_q[NUM_LOW+k]};
                    end
                end
            end
        endcase
    end

    read_wait_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && accept && !hwrite) |=> !hreadyout ##1 (hreadyout || !ce))
        else $error("read did not answer after one wait state");

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync1_q <= '0;
            lvl_q <= '0;
            pb_sync1_q <= 1'b0;
            pb_q <= 1'b0;
        end else if (ce) begin
            sync1_q <= pin_in;
            lvl_q <= sync1_q;
            pb_sync1_q <= pushbutton_input;
            pb_q <= pb_sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // low pin direction and data registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dir_q <= DIR_RST;
        end else if (wr_en) begin
            unique case (addr_q)
                IDX_PORT0: dir_q[3:0] <= wbyte[7:4];
                IDX_PORT1: dir_q[7:4] <= wbyte[7:4];
                IDX_PORT2: dir_q[11:8] <= wbyte[7:4];
                IDX_PORT3: dir_q[14:12] <= wbyte[6:4];
                default: dir_q <= dir_q;
            endcase
        end
    end

    // data latch: bits of input pins keep their old value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            val_q <= VAL_RST;
        end else if (wr_en) begin
            unique case (addr_q)
                IDX_PORT0: val_q[3:0] <= (wbyte[3:0] & dir_q[3:0]) | (val_q[3:0] & ~dir_q[3:0]);
                IDX_PORT1: val_q[7:4] <= (wbyte[3:0] & dir_q[7:4]) | (val_q[7:4] & ~dir_q[7:4]);
                IDX_PORT2: val_q[11:8] <= (wbyte[3:0] & dir_q[11:8]) | (val_q[11:8] & ~dir_q[11:8]);
                IDX_PORT3: val_q[14:12] <= (wbyte[2:0] & dir_q[14:12]) | (val_q[14:12] & ~dir_q[14:12]);
                default: val_q <= val_q;
            endcase
        end
    end

    input_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_en && addr_q == IDX_PORT0 && dir_q[3:0] == 4'h0) |=> val_q[3:0] == $past(val_q[3:0]))
        else $error("write changed the latch of an input pin");

    ////////////////////////////////////////////////////////////////////////////
    // high pin control bytes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int k = 0; k < NUM_HIGH; k++) begin
                high_q[k] <= HIGH_RST;
            end
        end else if (wr_en) begin
            for (int k = 0; k < NUM_HIGH; k++) begin
                if (addr_q == IDX_HIGH0 + 16'(k)) begin
                    high_q[k] <= wbyte[HIGH_DIR:HIGH_VAL];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // resource selectors and eeprom function
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                sel_q[i] <= SEL_RST;
            end
        end else if (wr_en) begin
            unique case (addr_q)
                IDX_SEL_PB: sel_q[0] <= wbyte[SEL_LO+:3];
                IDX_SEL_2: begin
                    sel_q[1] <= wbyte[SEL_LO+:3];
                    sel_q[2] <= wbyte[SEL_HI+:3];
                end
                IDX_SEL_4: begin
                    sel_q[3] <= wbyte[SEL_LO+:3];
                    sel_q[4] <= wbyte[SEL_HI+:3];
                end
                IDX_SEL_6: begin
                    sel_q[5] <= wbyte[SEL_LO+:3];
                    sel_q[6] <= wbyte[SEL_HI+:3];
                end
                IDX_SEL_8: begin
                    sel_q[7] <= wbyte[SEL_LO+:3];
                    sel_q[8] <= wbyte[SEL_HI+:3];
                end
                IDX_SEL_10: begin
                    sel_q[9] <= wbyte[SEL_LO+:3];
                    sel_q[10] <= wbyte[SEL_HI+:3];
                end
                default: sel_q[0] <= sel_q[0];
            endcase
        end
    end

    // eeprom pin function field
    always_ff @(posedge clk) begin
        if (!nrst) begin
            eex_q <= EEX_RST;
        end else if (wr_en && addr_q == IDX_EEX) begin
            eex_q <= wbyte[EEX_POS+:2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // resource routing: input 0 is the pushbutton, input i is pin i+1
    assign src[0] = pb_q;
    assign src[NUM_SRC-1:1] = lvl_q[NUM_SRC:2];

    generate
        for (genvar i = 0; i < NUM_SRC; i++) begin : g_route
            // codes 0 and 1 reach nothing
            assign contrib[i] = {sel_q[i] == RES_INTB, sel_q[i] == RES_INTA,
                                 sel_q[i] == RES_T1, sel_q[i] == RES_T0} & {4{src[i]}};
            assign sel_live[i] = (sel_q[i] != RES_NONE);
        end
    endgenerate

    // merge all inputs aimed at one resource
    always_comb begin
        res_or = 4'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            res_or = res_or | contrib[i];
        end
    end

    // resource output registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            res_q <= 4'h0;
        end else if (ce) begin
            res_q <= res_or;
        end
    end

    t0_route_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && sel_q[0] == RES_T0 && pb_q) |=> timer_zero_input)
        else $error("pushbutton on timer zero not routed");

    rsvd_none_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && sel_q[0] == RES_RSVD && sel_live == 11'h001) |=> res_q == 4'h0)
        else $error("reserved or none code reached a resource");

    or_merge_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && sel_q[1] == RES_INTA && sel_q[10] == RES_INTA && (lvl_q[2] || lvl_q[11]))
        |=> external_interrupt_a)
        else $error("two pins on one interrupt not ORed");

    int_b_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && sel_q[10] == RES_INTB && lvl_q[11]) |=> external_interrupt_b)
        else $error("pin 11 not routed to interrupt b");

    ////////////////////////////////////////////////////////////////////////////
    // pad drive, eeprom takeover of pins 2 and 3
    always_comb begin
        out_d = '0;
        oe_d = '0;
        out_d[NUM_LOW-1:0] = val_q;
        oe_d[NUM_LOW-1:0] = dir_q;
        for (int k = 0; k < NUM_HIGH; k++) begin
            out_d[NUM_LOW+k] = high_q[k][HIGH_VAL];
            oe_d[NUM_LOW+k] = high_q[k][HIGH_DIR];
        end
        if (eex_q != EEX_OFF) begin
            out_d[2] = eeprom_serial_clock;
            oe_d[2] = 1'b1;
            out_d[3] = eeprom_sda_out;
            oe_d[3] = eeprom_sda_oe;
        end
    end

    // pad and eeprom output registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
            sda_in_q <= 1'b0;
            ee_en_q <= 1'b0;
            ee_three_q <= 1'b0;
        end else if (ce) begin
            pin_out_q <= out_d;
            pin_oe_q <= oe_d;
            sda_in_q <= lvl_q[3];
            ee_en_q <= (eex_q != EEX_OFF);
            ee_three_q <= (eex_q != EEX_OFF) && (eex_q != EEX_TWO);
        end
    end

    dir_drive_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && eex_q == EEX_OFF) |=> pin_oe[NUM_LOW-1:0] == $past(dir_q))
        else $error("low pin enable does not follow direction");

    high_ctrl_a: assert property (@(posedge clk) disable iff (!nrst)
        ce |=> pin_oe[NUM_LOW] == $past(high_q[0][HIGH_DIR]) && pin_out[NUM_LOW] == $past(high_q[0][HIGH_VAL]))
        else $error("high pin not driven by its control byte");

    ee_pins_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && eex_q != EEX_OFF) |=> pin_oe[2] && pin_out[2] == $past(eeprom_serial_clock)
        && pin_oe[3] == $past(eeprom_sda_oe))
        else $error("eeprom pins not taken over");

    ee_mode_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && eex_q == EEX_TWO) |=> eeprom_enable && !eeprom_three_wire)
        else $error("two wire mode decoded wrong");

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0 & hreadyout_q;
    assign hrdata = hrdata_q;
    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign timer_zero_input = res_q[0];
    assign timer_one_input = res_q[1];
    assign external_interrupt_a = res_q[2];
    assign external_interrupt_b = res_q[3];
    assign eeprom_sda_in = sda_in_q;
    assign eeprom_enable = ee_en_q;
    assign eeprom_three_wire = ee_three_q;

endmodule : dpc_top
`default_nettype wire

// File: rtl/dpc_pkg.sv
// constants for the digital pin configuration block
`default_nettype none
package dpc_pkg;
    // pin counts
    localparam int NUM_LOW = 15;    // pins under the port bytes
    localparam int NUM_HIGH = 4;    // pins above 14, each with its own control byte
    localparam int NUM_PIN = NUM_LOW + NUM_HIGH;
    localparam int NUM_SRC = 11;    // pushbutton plus pins 2..11
    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_PORT0 = 16'h0080;
    localparam logic [15:0] IDX_PORT1 = 16'h0090;
    localparam logic [15:0] IDX_PORT2 = 16'h00a0;
    localparam logic [15:0] IDX_PORT3 = 16'h00b0;
    localparam logic [15:0] IDX_SEL_PB = 16'h2450;
    localparam logic [15:0] IDX_SEL_10 = 16'h2451;
    localparam logic [15:0] IDX_SEL_8 = 16'h2452;
    localparam logic [15:0] IDX_SEL_6 = 16'h2453;
    localparam logic [15:0] IDX_SEL_4 = 16'h2454;
    localparam logic [15:0] IDX_SEL_2 = 16'h2455;
    localparam logic [15:0] IDX_EEX = 16'h2456;
    localparam logic [15:0] IDX_HIGH0 = 16'h2460;  // control byte of pin 15, then 16..18
    // field positions
    localparam int SEL_LO = 0;      // selector of the even pin in a byte
    localparam int SEL_HI = 4;      // selector of the odd pin in a byte
    localparam int EEX_POS = 6;     // eeprom function field
    localparam int HIGH_VAL = 0;    // value bit of a high pin control byte
    localparam int HIGH_DIR = 1;    // direction bit of a high pin control byte
    // reset values
    localparam logic [14:0] DIR_RST = 15'h7fff;
    localparam logic [14:0] VAL_RST = 15'h7fff;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [1:0] EEX_RST = 2'h0;
    localparam logic [1:0] HIGH_RST = 2'h0;
    // resource selector codes
    localparam logic [2:0] RES_NONE = 3'h0;
    localparam logic [2:0] RES_RSVD = 3'h1;
    localparam logic [2:0] RES_T0 = 3'h2;
    localparam logic [2:0] RES_T1 = 3'h3;
    localparam logic [2:0] RES_INTA = 3'h4;
    localparam logic [2:0] RES_INTB = 3'h5;
    // eeprom pin function codes
    localparam logic [1:0] EEX_OFF = 2'h0;
    localparam logic [1:0] EEX_TWO = 2'h1;
    // bus phase states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WR = 2'b01,
        ST_RD = 2'b10
    } dpc_bus_st_t;
endpackage : dpc_pkg
`default_nettype wire

// File: verif/dpc_pad_model.sv
// pad model: outside world that sits on the pins of the pin configuration block
`default_nettype none
module dpc_pad_model (
    // pad side of the block
    input wire logic [dpc_pkg::NUM_PIN-1:0] pin_out,
    input wire logic [dpc_pkg::NUM_PIN-1:0] pin_oe,
    output logic [dpc_pkg::NUM_PIN-1:0] pin_in,
    // levels that outside drivers put on pins the block leaves alone
    input wire logic [dpc_pkg::NUM_PIN-1:0] ext_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    import dpc_pkg::*;
    //////////////////////////////////////////////////////////////////////////
    // block drive wins; otherwise the outside driver sets the wire level
    always_comb begin
        for (int i = 0; i < NUM_PIN; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
        end
    end
endmodule : dpc_pad_model
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the digital pin configuration block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dpc_pkg::*;
    //////////////////////////////////////////////////////////////////////////
    // bench signals, named after the block ports
    logic clk, nrst, ce, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, dummy;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [NUM_PIN-1:0] pin_in, pin_out, pin_oe, ext_lvl;
    logic pushbutton_input, timer_zero_input, timer_one_input, external_interrupt_a, external_interrupt_b;
    logic eeprom_serial_clock, eeprom_sda_out, eeprom_sda_oe, eeprom_sda_in, eeprom_enable, eeprom_three_wire;
    int n_mismatch = 0;  // failed comparisons
    int checks_done = 0;  // all comparisons
    //////////////////////////////////////////////////////////////////////////
    dpc_top uut (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pushbutton_input(pushbutton_input), .timer_zero_input(timer_zero_input),
        .timer_one_input(timer_one_input), .external_interrupt_a(external_interrupt_a),
        .external_interrupt_b(external_interrupt_b), .eeprom_serial_clock(eeprom_serial_clock),
        .eeprom_sda_out(eeprom_sda_out), .eeprom_sda_oe(eeprom_sda_oe), .eeprom_sda_in(eeprom_sda_in),
        .eeprom_enable(eeprom_enable), .eeprom_three_wire(eeprom_three_wire));
    dpc_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_lvl(ext_lvl));
    //////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // compare one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one single ahb transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr <= {14'h0, idx, 2'h0};
        hwrite <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin
            n_mismatch++;
            conclude();
        end
    endtask : bus
    // register write and checked register read
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, dummy);
    endtask : wr
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 8'h00, r);
        chk(r, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask : rd_chk
    // pads need two sync edges and one output edge, plus two to look past the last update
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask : settle
    //////////////////////////////////////////////////////////////////////////
    // reset values of direction, data and the pushbutton selector
    task automatic t_reset();
        rd_chk(IDX_PORT0, 32'h000000ff);
        rd_chk(IDX_PORT3, 32'h00000077);
        chk({13'h0, pin_oe}, 32'h00007fff);
        rd_chk(IDX_SEL_PB, 32'h0);
        $display("reset test done");
    endtask : t_reset
    // mixed directions in one port byte
    task automatic t_port();
        ext_lvl <= 19'h000c0;
        wr(IDX_PORT1, 8'h35);
        settle();
        chk({26'h0, pin_oe[7:4], pin_out[5:4]}, {26'h0, 4'h3, 2'b01});
        wr(IDX_PORT1, 8'h3a);
        settle();
        chk({26'h0, pin_oe[7:4], pin_out[5:4]}, {26'h0, 4'h3, 2'b10});
        rd_chk(IDX_PORT1, 32'h0000003e);
        wr(IDX_PORT1, 8'hf0);
        settle();
        chk({24'h0, pin_oe[7:4], pin_out[7:4]}, 32'h000000f4);
        $display("port test done");
    endtask : t_port
    // every selector code, every selector, and or-merging
    task automatic t_route();
        logic [3:0] exp;
        wr(IDX_PORT0, 8'h00);
        wr(IDX_PORT1, 8'h00);
        wr(IDX_PORT2, 8'h00);
        wr(IDX_PORT0, 8'h0f);
        ext_lvl <= '0;
        pushbutton_input <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(IDX_SEL_PB, 8'(c));
            settle();
            exp = (c >= 2 && c <= 5) ? 4'(1 << (c - 2)) : 4'h0;
            chk({28'h0, external_interrupt_b, external_interrupt_a, timer_one_input, timer_zero_input},
                {28'h0, exp});
        end
        wr(IDX_SEL_PB, 8'h00);
        pushbutton_input <= 1'b0;
        for (int p = 2; p < 12; p++) begin
            ext_lvl <= 19'(1 << p);
            wr(IDX_SEL_2 - 16'((p - 2) / 2), (p % 2) ? 8'h30 : 8'h03);
            settle();
            chk({31'h0, timer_one_input}, 32'h1);
            wr(IDX_SEL_2 - 16'((p - 2) / 2), 8'h00);
        end
        wr(IDX_SEL_2, 8'h04);
        wr(IDX_SEL_10, 8'h40);
        for (int k = 0; k < 4; k++) begin
            ext_lvl <= {7'h0, k[1], 8'h0, k[0], 2'h0};
            settle();
            chk({31'h0, external_interrupt_a}, {31'h0, |k[1:0]});
        end
        wr(IDX_SEL_10, 8'h50);
        settle();
        chk({30'h0, external_interrupt_b, external_interrupt_a}, 32'h3);
        $display("route test done");
    endtask : t_route
    // eeprom function codes and pin takeover
    task automatic t_eeprom();
        for (int m = 0; m < 4; m++) begin
            wr(IDX_EEX, 8'(m << 6));
            settle();
            chk({30'h0, eeprom_enable, eeprom_three_wire}, {30'h0, m != 0, m >= 2});
        end
        wr(IDX_EEX, 8'h40);
        eeprom_serial_clock <= 1'b1;
        eeprom_sda_oe <= 1'b1;
        eeprom_sda_out <= 1'b0;
        settle();
        chk({28'h0, pin_oe[3:2], pin_out[3:2]}, 32'h0000000d);
        eeprom_sda_oe <= 1'b0;
        ext_lvl <= 19'h00008;
        settle();
        chk({31'h0, eeprom_sda_in}, 32'h1);
        wr(IDX_EEX, 8'h00);
        settle();
        chk({30'h0, pin_oe[3:2]}, 32'h0);
        $display("eeprom test done");
    endtask : t_eeprom
    // high pin control byte and an unmapped read
    task automatic t_high();
        wr(IDX_HIGH0, 8'h03);
        settle();
        chk({30'h0, pin_oe[15], pin_out[15]}, 32'h3);
        rd_chk(IDX_HIGH0, 32'h00000003);
        wr(IDX_HIGH0, 8'h02);
        settle();
        chk({30'h0, pin_oe[15], pin_out[15]}, 32'h2);
        rd_chk(16'h3000, 32'h0);
        $display("high pin test done");
    endtask : t_high
    //////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // main sequence
    initial begin
        {nrst, hwrite, pushbutton_input, eeprom_serial_clock, eeprom_sda_out, eeprom_sda_oe} = '0;
        {ce, hsel} = 2'b11;
        {haddr, hwdata} = '0;
        htrans = 2'h0;
        hsize = 3'h2;
        ext_lvl = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        settle();
        t_reset();
        t_port();
        t_route();
        t_eeprom();
        t_high();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
